/* hdl/ftg_flash_trigger.sv */
// Trigger inputs, exposure control and flash trigger output with Avalon-MM registers
`timescale 1ns/10ps
`include "ftg_defines.svh"

module ftg_flash_trigger (
  input  wire logic                     clk,            // 100 MHz clock
  input  wire logic                     rst_b,          // Synchronous reset, active low
  input  wire logic [`FTG_ADDR_W-1:0]   address,        // Avalon byte address
  input  wire logic                     read,           // Avalon read
  input  wire logic                     write,          // Avalon write
  input  wire logic [31:0]              writedata,      // Avalon write data
  output logic      [31:0]              readdata,       // Avalon read data
  output logic                          waitrequest,    // Avalon wait request
  input  wire ftg_pkg::ftg_cc_s         cc,             // Camera control lines
  input  wire ftg_pkg::ftg_seq_s        seq,            // Sensor line strobes
  output ftg_pkg::ftg_drv_s             flash,          // Flash output driver
  output logic                          expo_active,    // Exposure under way
  output logic                          readout_start   // Frame readout pulse
);
  import ftg_pkg::*;

  localparam logic [31:0] STEP_NS_A  = 32'(`FTG_STEP_A_NS);
  localparam logic [31:0] STEP_NS_B  = 32'(`FTG_STEP_B_NS);
  localparam logic [31:0] STEP_NS_C  = 32'(`FTG_STEP_C_NS);
  localparam logic [31:0] STEP_CYC_A = 32'(`FTG_STEP_CYC(`FTG_STEP_A_NS));
  localparam logic [31:0] STEP_CYC_B = 32'(`FTG_STEP_CYC(`FTG_STEP_B_NS));
  localparam logic [31:0] STEP_CYC_C = 32'(`FTG_STEP_CYC(`FTG_STEP_C_NS));

  ftg_out_e           out_mode;
  ftg_sw_e            sw_mode;
  ftg_expo_e          expo_mode;
  ftg_var_e           variant;
  logic signed [15:0] ofs_raw;
  logic [31:0]        expo_time;
  logic [31:0]        min_flash;
  logic [11:0]        roi_lines;
  logic [31:0]        frames;

  logic               ack;
  logic               div_busy;
  logic               div_fin;
  logic               div_neg;
  logic [31:0]        div_rem;
  logic [14:0]        div_q;

  logic               trig_q;
  logic               trig_rise;
  logic               trig_fall;
  logic [31:0]        expo_cnt;

  logic               win_run;
  logic [31:0]        win_t;
  logic signed [31:0] open_at;
  logic signed [31:0] close_at;
  logic               window;
  logic               next_level;

  logic [31:0]        step_ns;
  logic [31:0]        step_cyc;
  logic signed [31:0] lines_m1;
  logic signed [31:0] ofs_ext;
  logic               ofs_ok;
  logic               ofs_avail;
  logic               flash_allowed;
  logic               is_abs_wr;

  // Variant step
  always_comb begin
    case (variant)
      FTG_VAR_B: begin
        step_ns  = STEP_NS_B;
        step_cyc = STEP_CYC_B;
      end
      FTG_VAR_C: begin
        step_ns  = STEP_NS_C;
        step_cyc = STEP_CYC_C;
      end
      default: begin
        step_ns  = STEP_NS_A;
        step_cyc = STEP_CYC_A;
      end
    endcase
  end

  assign lines_m1      = {20'h0_0000, roi_lines} - 32'sh0000_0001;
  assign ofs_ext       = 32'(ofs_raw);
  assign ofs_ok        = (ofs_ext <= lines_m1) && (-ofs_ext <= lines_m1);
  assign ofs_avail     = (expo_mode == FTG_EXPO_FREE) || (expo_mode == FTG_EXPO_PROG);
  assign flash_allowed = (expo_time >= min_flash);

  // Avalon-MM slave: one wait cycle, longer for an absolute offset write
  assign is_abs_wr   = write && (address == `FTG_REG_OFS_ABS);
  assign waitrequest = (read || write) && !ack;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack <= 1'b0;
    end else begin
      ack <= (read || write) && !ack && (!is_abs_wr || div_fin);
    end
  end

  // Absolute time to step count by repeated subtraction
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_busy <= 1'b0;
      div_fin  <= 1'b0;
      div_neg  <= 1'b0;
      div_rem  <= 32'h0000_0000;
      div_q    <= 15'h0000;
    end else if (is_abs_wr && !div_busy && !div_fin && !ack) begin
      div_busy <= 1'b1;
      div_neg  <= writedata[31];
      div_rem  <= writedata[31] ? (32'h0000_0000 - writedata) : writedata;
      div_q    <= 15'h0000;
    end else if (div_busy) begin
      if (div_rem >= step_ns && div_q != `FTG_RAW_MAX) begin
        div_rem <= div_rem - step_ns;
        div_q   <= div_q + 15'h0001;
      end else begin
        div_busy <= 1'b0;
        div_fin  <= 1'b1;
      end
    end else if (ack) begin
      div_fin <= 1'b0;
    end
  end

  // Register writes, taken at the edge where waitrequest is low
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      out_mode  <= FTG_OUT_LOW;
      sw_mode   <= FTG_SW_HIZ;
      ofs_raw   <= 16'sh0000;
      expo_mode <= FTG_EXPO_FREE;
      expo_time <= `FTG_RST_EXPO_TIME;
      min_flash <= `FTG_RST_MIN_FLASH;
      roi_lines <= `FTG_RST_ROI_LINES;
      variant   <= FTG_VAR_A;
    end else if (write && ack) begin
      case (address)
        `FTG_REG_OUT_MODE:  out_mode  <= ftg_out_e'(writedata[2:0]);
        `FTG_REG_SW_MODE:   sw_mode   <= ftg_sw_e'(writedata[1:0]);
        `FTG_REG_OFS_RAW:   ofs_raw   <= writedata[15:0];
        `FTG_REG_OFS_ABS:   ofs_raw   <= div_neg ? -$signed({1'b0, div_q}) : $signed({1'b0, div_q});
        `FTG_REG_EXPO_MODE: expo_mode <= ftg_expo_e'(writedata[1:0]);
        `FTG_REG_EXPO_TIME: expo_time <= writedata;
        `FTG_REG_MIN_FLASH: min_flash <= writedata;
        `FTG_REG_ROI_LINES: roi_lines <= writedata[11:0];
        `FTG_REG_VARIANT:   variant   <= ftg_var_e'(writedata[1:0]);
        default: ;
      endcase
    end
  end

  // Read data captured as the answer is raised
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ack) begin
      case (address)
        `FTG_REG_OUT_MODE:  readdata <= {29'h0000_0000, out_mode};
        `FTG_REG_SW_MODE:   readdata <= {30'h0000_0000, sw_mode};
        `FTG_REG_OFS_RAW:   readdata <= ofs_ext;
        `FTG_REG_OFS_ABS:   readdata <= 32'(ofs_ext * $signed(step_ns));
        `FTG_REG_EXPO_MODE: readdata <= {30'h0000_0000, expo_mode};
        `FTG_REG_EXPO_TIME: readdata <= expo_time;
        `FTG_REG_MIN_FLASH: readdata <= min_flash;
        `FTG_REG_ROI_LINES: readdata <= {20'h0_0000, roi_lines};
        `FTG_REG_VARIANT:   readdata <= {30'h0000_0000, variant};
        `FTG_REG_STATUS:    readdata <= {28'h000_0000, expo_active, ofs_ok, flash.level, window};
        `FTG_REG_FRAMES:    readdata <= frames;
        default:            readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Frame trigger edges, CC1 only
  assign trig_rise = cc.cc1 && !trig_q;
  assign trig_fall = !cc.cc1 && trig_q;

  // Reset to the idle high level so release gives no false edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      trig_q <= 1'b1;
    end else begin
      trig_q <= cc.cc1;
    end
  end

  // Exposure and readout under trigger control
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      expo_active   <= 1'b0;
      readout_start <= 1'b0;
      expo_cnt      <= 32'h0000_0000;
    end else begin
      readout_start <= 1'b0;
      case (expo_mode)
        FTG_EXPO_LEVEL: begin
          if (trig_fall) begin
            expo_active <= 1'b1;
          end else if (trig_rise && expo_active) begin
            expo_active   <= 1'b0;
            readout_start <= 1'b1;
          end
        end
        FTG_EXPO_PROG, FTG_EXPO_EDGE: begin
          if (!expo_active && trig_rise) begin
            expo_active <= 1'b1;
            expo_cnt    <= (expo_time == 32'h0000_0000) ? 32'h0000_0001 : expo_time;
          end else if (expo_active) begin
            expo_cnt <= expo_cnt - 32'h0000_0001;
            if (expo_cnt == 32'h0000_0001) begin
              expo_active   <= 1'b0;
              readout_start <= 1'b1;
            end
          end
        end
        default: begin
          expo_active <= 1'b0;
        end
      endcase
    end
  end

  // Frame counter, one per readout pulse
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      frames <= 32'h0000_0000;
    end else if (readout_start) begin
      frames <= frames + 32'h0000_0001;
    end
  end

  // Flash window from strobes, or shifted by the offset counter
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      win_run  <= 1'b0;
      win_t    <= 32'h0000_0000;
      open_at  <= 32'sh0000_0000;
      close_at <= 32'sh0000_0000;
      window   <= 1'b0;
    end else if (ofs_avail && ofs_raw != 16'sh0000) begin
      if (seq.first_start) begin
        win_run  <= ofs_ok;
        win_t    <= 32'h0000_0000;
        open_at  <= 32'((lines_m1 + ofs_ext) * $signed(step_cyc));
        close_at <= 32'($signed(expo_time) + ofs_ext * $signed(step_cyc));
        window   <= 1'b0;
      end else if (win_run) begin
        win_t <= win_t + 32'h0000_0001;
        if ($signed(win_t) == close_at) begin
          window  <= 1'b0;
          win_run <= 1'b0;
        end else if ($signed(win_t) == open_at) begin
          window <= 1'b1;
        end
      end
    end else begin
      win_run <= 1'b0;
      if (seq.first_end) begin
        window <= 1'b0;
      end else if (seq.last_start) begin
        window <= 1'b1;
      end
    end
  end

  // Output selection; the window modes are gated by the minimum flash exposure
  always_comb begin
    case (out_mode)
      FTG_OUT_HIGH:     next_level = 1'b1;
      FTG_OUT_WIN_HIGH: next_level = window && flash_allowed;
      FTG_OUT_WIN_LOW:  next_level = !(window && flash_allowed);
      FTG_OUT_PASS:     next_level = cc.cc3;
      FTG_OUT_PASS_INV: next_level = !cc.cc3;
      default:          next_level = 1'b0;
    endcase
  end

  // Driver transistors per switching style
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flash <= '{level: 1'b0, pu_en: 1'b0, pd_en: 1'b0};
    end else begin
      flash.level <= next_level;
      case (sw_mode)
        FTG_SW_TTL: begin
          flash.pu_en <= next_level;
          flash.pd_en <= !next_level;
        end
        FTG_SW_LOW_SIDE: begin
          flash.pu_en <= 1'b0;
          flash.pd_en <= !next_level;
        end
        FTG_SW_HIGH_SIDE: begin
          flash.pu_en <= next_level;
          flash.pd_en <= 1'b0;
        end
        default: begin
          flash.pu_en <= 1'b0;
          flash.pd_en <= 1'b0;
        end
      endcase
    end
  end

  // Driver, selection, window and exposure readout checks
  a_low_side_pu: assert property (@(posedge clk) disable iff (!rst_b)
    $past(sw_mode) == FTG_SW_LOW_SIDE |-> !flash.pu_en)
    else $error("Upper transistor on in low side style");
  a_high_side_pd: assert property (@(posedge clk) disable iff (!rst_b)
    $past(sw_mode) == FTG_SW_HIGH_SIDE |-> !flash.pd_en)
    else $error("Lower transistor on in high side style");
  a_hiz_both_off: assert property (@(posedge clk) disable iff (!rst_b)
    $past(sw_mode) == FTG_SW_HIZ |-> !flash.pu_en && !flash.pd_en)
    else $error("Driver active in high impedance style");
  a_static_level: assert property (@(posedge clk) disable iff (!rst_b)
    $past(out_mode) inside {FTG_OUT_LOW, FTG_OUT_HIGH} |-> flash.level == ($past(out_mode) == FTG_OUT_HIGH))
    else $error("Static flash level wrong");
  a_pass_follow: assert property (@(posedge clk) disable iff (!rst_b)
    $past(out_mode) inside {FTG_OUT_PASS, FTG_OUT_PASS_INV}
      |-> flash.level == ($past(cc.cc3) ^ ($past(out_mode) == FTG_OUT_PASS_INV)))
    else $error("Pass-through level wrong");
  a_short_expo_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    $past(out_mode) == FTG_OUT_WIN_HIGH && !$past(flash_allowed) |-> !flash.level)
    else $error("Flash pulse with too short exposure");
  a_window_open_last: assert property (@(posedge clk) disable iff (!rst_b)
    !(ofs_avail && ofs_raw != 16'sh0000) && seq.last_start && !seq.first_end && out_mode == FTG_OUT_WIN_HIGH
      && flash_allowed ##1 out_mode == FTG_OUT_WIN_HIGH && flash_allowed |=> flash.level)
    else $error("Window high did not rise on last line start");
  a_window_low_mode: assert property (@(posedge clk) disable iff (!rst_b)
    $past(out_mode) == FTG_OUT_WIN_LOW |-> flash.level == !($past(window) && $past(flash_allowed)))
    else $error("Window low level wrong");
  a_readout_on_rise: assert property (@(posedge clk) disable iff (!rst_b)
    expo_mode == FTG_EXPO_LEVEL && expo_active && trig_rise |=> readout_start && !expo_active)
    else $error("Level mode readout missing on rising trigger");
  a_bad_offset_shut: assert property (@(posedge clk) disable iff (!rst_b)
    ofs_avail && ofs_raw != 16'sh0000 && seq.first_start && !ofs_ok |=> !win_run)
    else $error("Window counter started with offset out of range");

  // Main scenarios
  c_level_frame: cover property (@(posedge clk) disable iff (!rst_b) expo_mode == FTG_EXPO_LEVEL && readout_start);
  c_prog_frame: cover property (@(posedge clk) disable iff (!rst_b) expo_mode == FTG_EXPO_PROG && readout_start);
  c_offset_window: cover property (@(posedge clk) disable iff (!rst_b) win_run && $rose(window));
  c_abs_write: cover property (@(posedge clk) disable iff (!rst_b) is_abs_wr && ack);

endmodule : ftg_flash_trigger

/* hdl/ftg_defines.svh */
// Offsets, field positions, reset values and timing counts of the flash trigger block
`ifndef FTG_DEFINES_SVH
`define FTG_DEFINES_SVH

`define FTG_CLK_PERIOD_NS   10
`define FTG_ADDR_W          6

`define FTG_REG_OUT_MODE    6'h00
`define FTG_REG_SW_MODE     6'h04
`define FTG_REG_OFS_RAW     6'h08
`define FTG_REG_OFS_ABS     6'h0C
`define FTG_REG_EXPO_MODE   6'h10
`define FTG_REG_EXPO_TIME   6'h14
`define FTG_REG_MIN_FLASH   6'h18
`define FTG_REG_ROI_LINES   6'h1C
`define FTG_REG_VARIANT     6'h20
`define FTG_REG_STATUS      6'h24
`define FTG_REG_FRAMES      6'h28

`define FTG_RST_EXPO_TIME   32'h0000_03E8
`define FTG_RST_MIN_FLASH   32'h0000_0064
`define FTG_RST_ROI_LINES   12'h0_40

`define FTG_STAT_WINDOW     0
`define FTG_STAT_LEVEL      1
`define FTG_STAT_OFS_OK     2
`define FTG_STAT_EXPOSING   3

`define FTG_STEP_A_NS       4560
`define FTG_STEP_B_NS       3455
`define FTG_STEP_C_NS       2764
`define FTG_STEP_CYC(ns)    ((ns) / `FTG_CLK_PERIOD_NS)

`define FTG_RAW_MAX         15'h7FFF

`endif

/* hdl/ftg_pkg.sv */
// Types of the flash trigger block
package ftg_pkg;

  typedef enum logic [2:0] {
    FTG_OUT_LOW,
    FTG_OUT_HIGH,
    FTG_OUT_WIN_HIGH,
    FTG_OUT_WIN_LOW,
    FTG_OUT_PASS,
    FTG_OUT_PASS_INV
  } ftg_out_e;

  typedef enum logic [1:0] {
    FTG_SW_TTL,
    FTG_SW_LOW_SIDE,
    FTG_SW_HIGH_SIDE,
    FTG_SW_HIZ
  } ftg_sw_e;

  typedef enum logic [1:0] {
    FTG_EXPO_FREE,
    FTG_EXPO_LEVEL,
    FTG_EXPO_PROG,
    FTG_EXPO_EDGE
  } ftg_expo_e;

  typedef enum logic [1:0] {
    FTG_VAR_A,
    FTG_VAR_B,
    FTG_VAR_C
  } ftg_var_e;

  // Camera control lines from the frame grabber
  typedef struct packed {
    logic cc1;
    logic cc2;
    logic cc3;
    logic cc4;
  } ftg_cc_s;

  // Flash output driver: logic level and the two transistor enables
  typedef struct packed {
    logic level;
    logic pu_en;
    logic pd_en;
  } ftg_drv_s;

  // Sensor sequencer strobes, one-cycle pulses
  typedef struct packed {
    logic first_start;
    logic first_end;
    logic last_start;
  } ftg_seq_s;

endpackage : ftg_pkg

/* dv/ftg_grabber_model.sv */
// Frame grabber model driving the camera control lines
`timescale 1ns/10ps
module ftg_grabber_model (
  input  wire logic        clk, // Camera clock
  output ftg_pkg::ftg_cc_s cc   // Camera control lines
);
  import ftg_pkg::*;
  logic trig_line  = 1'b1;
  logic flash_line = 1'b0;
  logic noise      = 1'b0;

  // Unused lines toggle every cycle so any use of them shows
  always @(posedge clk) begin
    noise <= ~noise;
  end
  assign cc = '{cc1: trig_line, cc2: noise, cc3: flash_line, cc4: ~noise};

  // Each frame needs a fresh edge, so the line is toggled per frame
  task automatic trig(input logic v, input int hold);
    @(posedge clk);
    trig_line <= v;
    repeat (hold) @(posedge clk);
  endtask : trig

  // Callers hold each level at least 100 cycles (1 us)
  task automatic flash_req(input logic v, input int hold);
    @(posedge clk);
    flash_line <= v;
    repeat (hold) @(posedge clk);
  endtask : flash_req
endmodule : ftg_grabber_model

/* dv/tb_ftg_flash_trigger.sv */
// Self-checking testbench of the flash trigger block
`timescale 1ns/10ps
`include "ftg_defines.svh"
module tb_ftg_flash_trigger;
  import ftg_pkg::*;
  logic        clk       = 1'b0;
  logic        rst_b     = 1'b0;
  logic [5:0]  address   = '0;
  logic        read      = 1'b0;
  logic        write     = 1'b0;
  logic [31:0] writedata = '0;
  logic [31:0] readdata;
  logic        waitrequest;
  ftg_cc_s     cc;
  ftg_seq_s    seq       = '0;
  ftg_drv_s    flash;
  logic        expo_active;
  logic        readout_start;
  logic [31:0] rd;
  int          errors    = 0;
  int          cmp_count = 0;
  int          rs_cnt    = 0;
  int          m;
  int          m2;
  logic [31:0] f0;

  always #5 clk = ~clk;

  ftg_flash_trigger ftg_flash_trigger_i (
    .clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .cc(cc), .seq(seq), .flash(flash), .expo_active(expo_active),
    .readout_start(readout_start)
  );

  ftg_grabber_model ftg_grabber_model_i (.clk(clk), .cc(cc));

  // Readout pulses seen on the output itself
  always @(posedge clk) begin
    if (readout_start === 1'b1) begin
      rs_cnt <= rs_cnt + 1;
    end
  end

  task automatic summarize;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // Request held until waitrequest is sampled low at a rising edge, then released
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk);
    address   <= a;
    writedata <= d;
    write     <= wr;
    read      <= ~wr;
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 5000);
    if (waitrequest !== 1'b0) begin
      errors++;
      $display("Error at %0t: bus timeout", $time);
      summarize();
    end
    q = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask : wr

  task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, rd);
    chk(rd, exp);
  endtask : rdchk

  task automatic strobe(input ftg_seq_s s);
    @(posedge clk);
    seq <= s;
    @(posedge clk);
    seq <= '0;
  endtask : strobe

  task automatic measure(input logic v, input int lim, output int n);
    n = 0;
    while (flash.level !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : measure

  initial begin
    repeat (2) @(posedge clk);
    chk(flash, 3'b000);
    rst_b <= 1'b1;
    rdchk(`FTG_REG_OUT_MODE, 32'h0000_0000);
    rdchk(`FTG_REG_SW_MODE, 32'h0000_0003);
    rdchk(`FTG_REG_OFS_RAW, 32'h0000_0000);
    rdchk(`FTG_REG_EXPO_TIME, `FTG_RST_EXPO_TIME);
    rdchk(`FTG_REG_MIN_FLASH, `FTG_RST_MIN_FLASH);
    rdchk(`FTG_REG_ROI_LINES, 32'(`FTG_RST_ROI_LINES));
    wr(6'h2C, 32'h0000_1234);
    rdchk(6'h2C, 32'h0000_0000);
    $display("Test reset and map done");

    // Static levels under every driver style
    for (int o = 0; o < 2; o++) begin
      for (int s = 0; s < 4; s++) begin
        wr(`FTG_REG_OUT_MODE, 32'(o));
        wr(`FTG_REG_SW_MODE, 32'(s));
        repeat (3) @(posedge clk);
        chk(flash, {o[0], o[0] & (s == 0 || s == 2), ~o[0] & (s == 0 || s == 1)});
      end
    end
    $display("Test driver styles done");

    wr(`FTG_REG_SW_MODE, 32'h0000_0000);
    for (int o = 4; o < 6; o++) begin
      wr(`FTG_REG_OUT_MODE, 32'(o));
      ftg_grabber_model_i.flash_req(1'b1, 100);
      chk(flash.level, o == 4);
      ftg_grabber_model_i.flash_req(1'b0, 100);
      chk(flash.level, o == 5);
    end
    $display("Test pass-through done");

    for (int o = 2; o < 4; o++) begin
      wr(`FTG_REG_OUT_MODE, 32'(o));
      repeat (3) @(posedge clk);
      chk(flash.level, o == 3);
      strobe('{first_start: 1'b0, first_end: 1'b0, last_start: 1'b1});
      repeat (3) @(posedge clk);
      chk(flash.level, o == 2);
      strobe('{first_start: 1'b0, first_end: 1'b1, last_start: 1'b0});
      repeat (3) @(posedge clk);
      chk(flash.level, o == 3);
    end
    wr(`FTG_REG_OUT_MODE, 32'h0000_0002);
    wr(`FTG_REG_EXPO_TIME, 32'h0000_0032);
    strobe('{first_start: 1'b0, first_end: 1'b0, last_start: 1'b1});
    repeat (3) @(posedge clk);
    chk(flash.level, 1'b0);
    strobe('{first_start: 1'b0, first_end: 1'b1, last_start: 1'b0});
    wr(`FTG_REG_EXPO_TIME, `FTG_RST_EXPO_TIME);
    $display("Test flash window done");

    wr(`FTG_REG_VARIANT, 32'h0000_0002);
    wr(`FTG_REG_OFS_RAW, 32'h0000_FFFB);
    rdchk(`FTG_REG_OFS_RAW, 32'hFFFF_FFFB);
    wr(`FTG_REG_OFS_ABS, 32'(3 * `FTG_STEP_C_NS));
    rdchk(`FTG_REG_OFS_RAW, 32'h0000_0003);
    rdchk(`FTG_REG_OFS_ABS, 32'(3 * `FTG_STEP_C_NS));
    wr(`FTG_REG_ROI_LINES, 32'h0000_0002);
    wr(`FTG_REG_OFS_RAW, 32'h0000_0001);
    strobe('{first_start: 1'b1, first_end: 1'b0, last_start: 1'b0});
    measure(1'b1, 3000, m);
    chk(32'(m >= 550 && m <= 558), 32'h0000_0001);
    measure(1'b0, 3000, m2);
    chk(32'(m + m2 >= 1274 && m + m2 <= 1282), 32'h0000_0001);
    wr(`FTG_REG_OFS_RAW, 32'h0000_0002);
    strobe('{first_start: 1'b1, first_end: 1'b0, last_start: 1'b0});
    measure(1'b1, 2000, m);
    chk(32'(m), 32'd2000);
    wr(`FTG_REG_OFS_RAW, 32'h0000_0001);
    wr(`FTG_REG_EXPO_MODE, 32'h0000_0001);
    strobe('{first_start: 1'b0, first_end: 1'b0, last_start: 1'b1});
    measure(1'b1, 10, m);
    chk(32'(m <= 3), 32'h0000_0001);
    rdchk(`FTG_REG_STATUS, 32'h0000_0007);
    $display("Test offset done");

    wr(`FTG_REG_EXPO_TIME, 32'h0000_0014);
    for (int md = 1; md < 4; md++) begin
      wr(`FTG_REG_EXPO_MODE, 32'(md));
      bus(1'b0, `FTG_REG_FRAMES, 32'h0000_0000, f0);
      m2 = rs_cnt;
      ftg_grabber_model_i.trig(1'b0, 10);
      chk(expo_active, md == 1);
      ftg_grabber_model_i.trig(1'b1, 5);
      chk(expo_active, md != 1);
      ftg_grabber_model_i.trig(1'b1, 40);
      chk(expo_active, 1'b0);
      rdchk(`FTG_REG_FRAMES, f0 + 32'h0000_0001);
      chk(32'(rs_cnt - m2), 32'h0000_0001);
    end
    $display("Test trigger modes done");
    summarize();
  end
endmodule : tb_ftg_flash_trigger
